//--- verification/pdsm_host_model.sv
// Host controller model issuing single-cycle register reads
`timescale 1ns/1ps
module pdsm_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] addr,
    output logic reg_rd,
    output logic [7:0] reg_addr
);
    initial begin
        reg_rd = 1'b0;
        reg_addr = 8'h00;
    end
    // Idle address toggles so a stale one never reads right by chance
    always @(posedge clk) begin
        reg_rd <= go;
        reg_addr <= go ? addr : ~reg_addr;
    end
endmodule : pdsm_host_model

//--- verification/tb_top.sv
// Self-checking bench for the path state tail and flag gating
`timescale 1ns/1ps
module tb_top;
    import pdsm_pkg::*;
    logic CLK = 0, RST = 1, CE = 1, REINIT_WR = 0, go = 0, rd_d = 0, REG_RD;
    pdsm_mod_state_type MOD_STATE = MS_OPERATIONAL;
    logic [3:0] DEACT = 4'h0, NOREQ = 4'h0, INIT_DONE = 4'hF, DEINIT_DONE = 4'h0;
    logic [7:0] DIS = 8'h00, SQ = 8'h00, RDY = 8'h3F, QUIET = 8'hFF;
    logic [7:0] BITS = 8'h00, addr = 8'h00;
    logic [7:0] REG_ADDR, REG_RDATA, TX_QUIESCE, STATE_CHANGED;
    logic [23:0] LANE_STATE;
    logic [31:0] ev = 32'h0, FLAG_EVENTS = 32'h0;
    logic [7:0] exp_q[$];
    int num_errors = 0, n_checks = 0, sc0 = 0, sc2 = 0, m, b;
    integer seed = 32'hf2e7;
    pdsm_top dut (.CLK(CLK), .CE(CE), .RST(RST), .MOD_STATE(MOD_STATE),
        .DEACTIVATE_REQ(DEACT), .REDEINIT_REQ(NOREQ), .DEINIT_REQ(NOREQ),
        .INIT_DONE(INIT_DONE), .DEINIT_DONE(DEINIT_DONE),
        .TX_LANE_DISABLE(DIS), .TX_LANE_FORCED_SQUELCH(SQ),
        .TX_LANE_READY(RDY), .TX_LANE_QUIET(QUIET), .REINIT_WR(REINIT_WR),
        .REINIT_REQUEST_BITS(BITS), .FLAG_EVENTS(FLAG_EVENTS),
        .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .TX_QUIESCE(TX_QUIESCE), .LANE_STATE(LANE_STATE),
        .STATE_CHANGED(STATE_CHANGED));
    pdsm_host_model host (.clk(CLK), .go(go), .addr(addr), .reg_rd(REG_RD),
        .reg_addr(REG_ADDR));
    initial begin
        forever #5 CLK = ~CLK;
    end
    // =====
    // Checking
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp
    // Bounded wait on the first lane of a path
    task automatic wait_st(input int p, input pdsm_path_state_type s);
        int i;
        for (i = 0; i < 40 && LANE_STATE[6*p+:3] !== s; i++) begin
            @(posedge CLK);
            #1;
        end
        cmp(8'(LANE_STATE[6*p+:3]), 8'(s));
        if (i == 40) begin
            end_of_test();
        end
    endtask : wait_st
    function automatic logic [7:0] allow(pdsm_mod_state_type ms, int by);
        if (ms < MS_LOW_POWER || by == 4) return 8'h00;
        if (ms inside {MS_LOW_POWER, MS_FAULTED}) return by < 2 ? 8'hFF : 8'h00;
        return 8'hFF;
    endfunction : allow
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK) go <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge CLK) go <= 1'b0;
    endtask : rd
    // Read data lands one cycle after the strobe is taken
    always @(posedge CLK) begin
        rd_d <= REG_RD & CE;
        if (rd_d) begin
            cmp(REG_RDATA, exp_q.pop_front());
        end
        if (STATE_CHANGED[0]) sc0++;
        if (STATE_CHANGED[4]) sc2++;
    end
    // =====
    // Stimulus
    initial begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        #1;
        cmp(LANE_STATE[7:0], 8'h00);
        cmp(TX_QUIESCE, 8'hFF);
        for (m = 0; m < 3; m++) wait_st(m, PS_OPERATIONAL);
        wait_st(3, PS_TX_TURNING_ON);
        cmp(TX_QUIESCE, 8'h00);
        @(posedge CLK) DEACT <= 4'h8;
        wait_st(3, PS_INITIALIZED);
        @(posedge CLK) DEACT <= 4'h0;
        RDY <= 8'hFF;
        wait_st(3, PS_OPERATIONAL);
        sc0 = 0;
        sc2 = 0;
        @(posedge CLK) REINIT_WR <= 1'b1;
        BITS <= 8'h03;
        @(posedge CLK) REINIT_WR <= 1'b0;
        wait_st(0, PS_DEINITIALIZING);
        repeat (3) @(posedge CLK);
        #1;
        cmp(8'(LANE_STATE[2:0]), 8'(PS_DEINITIALIZING));
        cmp(8'(TX_QUIESCE[1:0]), 8'h03);
        @(posedge CLK) DEINIT_DONE <= 4'hF;
        wait_st(0, PS_OPERATIONAL);
        @(posedge CLK);
        #1;
        cmp(8'(sc0), 8'h01);
        cmp(8'(sc2), 8'h00);
        cmp(8'(LANE_STATE[14:12]), 8'(PS_OPERATIONAL));
        @(posedge CLK) QUIET <= 8'hFB;
        DIS <= 8'h04;
        wait_st(1, PS_TX_TURNING_OFF);
        repeat (3) @(posedge CLK);
        #1;
        cmp(8'(LANE_STATE[8:6]), 8'(PS_TX_TURNING_OFF));
        cmp(8'(TX_QUIESCE[3:2]), 8'h01);
        @(posedge CLK) QUIET <= 8'hFF;
        wait_st(1, PS_INITIALIZED);
        @(posedge CLK) DIS <= 8'h00;
        wait_st(1, PS_OPERATIONAL);
        for (m = 0; m < 8; m++) begin
            ev = $random(seed);
            @(posedge CLK) MOD_STATE <= pdsm_mod_state_type'(m);
            FLAG_EVENTS <= ev;
            @(posedge CLK) FLAG_EVENTS <= 32'h0;
            for (b = 0; b < 5; b++) begin
                rd(8'h08 + 8'(b),
                    ev[8*(b%4)+:8] & allow(pdsm_mod_state_type'(m), b));
            end
        end
        repeat (6) @(posedge CLK);
        end_of_test();
    end
endmodule : tb_top

//--- verilog/pdsm_consts.svh
// Constants for the data path state tail and module flag gating
`ifndef PDSM_CONSTS_SVH
`define PDSM_CONSTS_SVH
// ============================================================
// Module flag register byte offsets
`define PDSM_OFS_EVENT 8'h08
`define PDSM_OFS_TEMP 8'h09
`define PDSM_OFS_AUX 8'h0A
`define PDSM_OFS_CUSTOM 8'h0B
// ============================================================
// Flag byte positions inside the flat flag vector
`define PDSM_IDX_EVENT 0
`define PDSM_IDX_TEMP 1
`define PDSM_IDX_AUX 2
`define PDSM_IDX_CUSTOM 3
`define PDSM_FLAG_BYTES 4
`define PDSM_BYTE_BITS 8
// ============================================================
// Values
`define PDSM_FLAG_RESET 8'h00
`define PDSM_ALL_ALLOWED 8'hFF
`define PDSM_NONE_ALLOWED 8'h00
`define PDSM_RDATA_UNMAPPED 8'h00
`define PDSM_STATE_BITS 3
`endif

//--- verilog/pdsm_flag_gate.sv
// Module state gating of module-level flag bytes
`timescale 1ns/1ps
`include "pdsm_consts.svh"
module pdsm_flag_gate #(
    parameter logic [7:0] LP_CUSTOM_MASK = 8'h00
) (
    input pdsm_pkg::pdsm_mod_state_type mod_state,
    output logic [31:0] allow
);
    import pdsm_pkg::*;

    function automatic logic in_reset_group(pdsm_mod_state_type s);
        in_reset_group = (s == MS_RESETTING) || (s == MS_RESET) ||
            (s == MS_MGMT_INIT);
    endfunction : in_reset_group

    function automatic logic in_low_group(pdsm_mod_state_type s);
        in_low_group = (s == MS_LOW_POWER) || (s == MS_FAULTED);
    endfunction : in_low_group

    // ============================================================
    // Allow mask per flag byte; data path state plays no part
    always_comb begin
        allow = '0;
        if (!in_reset_group(mod_state)) begin // [RULE19] [RULE20]
            allow[`PDSM_IDX_EVENT*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS] =
                `PDSM_ALL_ALLOWED;
            allow[`PDSM_IDX_TEMP*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS] =
                `PDSM_ALL_ALLOWED;
            if (in_low_group(mod_state)) begin
                allow[`PDSM_IDX_AUX*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS] =
                    `PDSM_NONE_ALLOWED; // [RULE21]
                // Only monitors that still work in low power
                allow[`PDSM_IDX_CUSTOM*`PDSM_BYTE_BITS +:
                    `PDSM_BYTE_BITS] = LP_CUSTOM_MASK; // [RULE22]
            end else begin
                allow[`PDSM_IDX_AUX*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS] =
                    `PDSM_ALL_ALLOWED; // [RULE21]
                allow[`PDSM_IDX_CUSTOM*`PDSM_BYTE_BITS +:
                    `PDSM_BYTE_BITS] = `PDSM_ALL_ALLOWED;
            end
        end
    end
endmodule : pdsm_flag_gate

//--- verilog/pdsm_path_fsm.sv
// One data path state machine
`timescale 1ns/1ps
`include "pdsm_consts.svh"
module pdsm_path_fsm (
    input wire logic clk,
    input wire logic ce,
    input wire logic rst,
    input wire logic deactivate_transition,
    input wire logic redeinit_transition,
    input wire logic deinit_transition,
    input wire logic init_done,
    input wire logic deinit_done,
    input wire logic tx_on_done,
    input wire logic tx_off_done,
    output pdsm_pkg::pdsm_path_state_type path_state,
    output pdsm_pkg::pdsm_path_state_type path_state_next
);
    import pdsm_pkg::*;

    pdsm_path_state_type state_reg;
    pdsm_path_state_type state_next;

    // ============================================================
    // Next state, evaluated once per enabled clock
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            case (state_reg)
                PS_DEACTIVATED: begin
                    if (!deinit_transition) begin
                        state_next = PS_INITIALIZING;
                    end
                end
                PS_INITIALIZING: begin
                    if (deinit_transition) begin
                        state_next = PS_DEINITIALIZING;
                    end else if (init_done) begin
                        state_next = PS_INITIALIZED;
                    end
                end
                PS_INITIALIZED: begin
                    // Re-deinit has priority over turning on
                    if (redeinit_transition) begin // [RULE23]
                        state_next = PS_DEINITIALIZING;
                    end else if (!deactivate_transition) begin
                        state_next = PS_TX_TURNING_ON;
                    end
                end
                PS_DEINITIALIZING: begin
                    if (deinit_done) begin // [RULE3]
                        state_next = PS_DEACTIVATED;
                    end
                end
                PS_TX_TURNING_ON: begin
                    if (deactivate_transition) begin // [RULE7]
                        state_next = PS_TX_TURNING_OFF;
                    end else if (tx_on_done) begin // [RULE8]
                        state_next = PS_OPERATIONAL;
                    end
                end
                PS_OPERATIONAL: begin
                    if (deactivate_transition) begin // [RULE10]
                        state_next = PS_TX_TURNING_OFF;
                    end
                end
                PS_TX_TURNING_OFF: begin
                    if (tx_off_done) begin // [RULE18]
                        state_next = PS_INITIALIZED;
                    end
                end
                default: begin
                    state_next = PS_DEACTIVATED;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= PS_DEACTIVATED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign path_state = state_reg;
    assign path_state_next = state_next;
endmodule : pdsm_path_fsm

//--- verilog/pdsm_pkg.sv
// Types for the data path state tail and module flag gating
package pdsm_pkg;
    typedef enum logic [2:0] {
        PS_DEACTIVATED,
        PS_INITIALIZING,
        PS_INITIALIZED,
        PS_DEINITIALIZING,
        PS_TX_TURNING_ON,
        PS_OPERATIONAL,
        PS_TX_TURNING_OFF
    } pdsm_path_state_type;

    typedef enum logic [2:0] {
        MS_RESETTING,
        MS_RESET,
        MS_MGMT_INIT,
        MS_LOW_POWER,
        MS_POWERING_UP,
        MS_OPERATIONAL,
        MS_POWERING_DOWN,
        MS_FAULTED
    } pdsm_mod_state_type;
endpackage : pdsm_pkg

//--- verilog/pdsm_top.sv
// Data path state tail per path and gated module flag registers
//
// Behaviour
// [RULE1] In deinitializing, every transmit lane of the path is driven quiet.
// [RULE2] Disable and squelch controls do not change quiet while deinit.
// [RULE3] Deinitializing leaves for deactivated only when deinit is done.
// [RULE4] Turning on unmutes all transmit lanes; auto-squelch may still act.
// [RULE5] State entry updates lane state; operational entry sets changed flag.
// [RULE6] Turning on: transmit in transition, receive follows its status.
// [RULE7] Deactivate during turning on moves the path to turning off.
// [RULE8] Turning on becomes operational once all lanes are ready.
// [RULE9] Operational keeps every transmit lane unmuted.
// [RULE10] Deactivate in operational moves the path to turning off.
// [RULE11] Reinit request makes deactivate true and runs the full loop.
// [RULE12] Host writes equal reinit bits to all lanes of a path.
// [RULE13] Host sets all reinit bits of a path in one write.
// [RULE14] Paths without selected lanes ignore a reinit write.
// [RULE15] Host supplies a valid input signal before requesting reinit.
// [RULE16] Lane disable or forced squelch makes deactivate true.
// [RULE17] Turning off applies per-lane disable and squelch settings.
// [RULE18] Turning off ends in initialized once lanes are quiet; the code waits only on lanes with disable or forced squelch set.
// [RULE19] No module flag is set where its module state forbids it.
// [RULE20] All module flags suppressed in resetting, reset, mgmt init.
// [RULE21] Aux monitor flag byte settable only in power up, down, ready.
// [RULE22] Custom monitor flags in low power only for low power monitors.
// [RULE23] Initialized turns on when deactivate false; re-deinit wins.
// [RULE24] One state machine per path, stepped once per clock.
`timescale 1ns/1ps
`include "pdsm_consts.svh"
module pdsm_top #(
    parameter int PATHS = 4,
    parameter int LANES_PER_PATH = 2,
    parameter logic [7:0] LP_CUSTOM_MASK = 8'h00
) (
    input wire logic CLK,
    input wire logic CE,
    input wire logic RST,
    input pdsm_pkg::pdsm_mod_state_type MOD_STATE,
    input wire logic [PATHS-1:0] DEACTIVATE_REQ,
    input wire logic [PATHS-1:0] REDEINIT_REQ,
    input wire logic [PATHS-1:0] DEINIT_REQ,
    input wire logic [PATHS-1:0] INIT_DONE,
    input wire logic [PATHS-1:0] DEINIT_DONE,
    input wire logic [PATHS*LANES_PER_PATH-1:0] TX_LANE_DISABLE,
    input wire logic [PATHS*LANES_PER_PATH-1:0] TX_LANE_FORCED_SQUELCH,
    input wire logic [PATHS*LANES_PER_PATH-1:0] TX_LANE_READY,
    input wire logic [PATHS*LANES_PER_PATH-1:0] TX_LANE_QUIET,
    input wire logic REINIT_WR,
    input wire logic [PATHS*LANES_PER_PATH-1:0] REINIT_REQUEST_BITS,
    input wire logic [31:0] FLAG_EVENTS,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [PATHS*LANES_PER_PATH-1:0] TX_QUIESCE,
    output logic [PATHS*LANES_PER_PATH*3-1:0] LANE_STATE,
    output logic [PATHS*LANES_PER_PATH-1:0] STATE_CHANGED
);
    import pdsm_pkg::*;

    localparam int LANES = PATHS * LANES_PER_PATH;

    // ============================================================
    // Lane to path helpers and flag byte offset lookup
    function automatic logic any_in_path(logic [LANES-1:0] v, int p);
        any_in_path = |v[p*LANES_PER_PATH +: LANES_PER_PATH];
    endfunction : any_in_path

    function automatic logic all_in_path(logic [LANES-1:0] v, int p);
        all_in_path = &v[p*LANES_PER_PATH +: LANES_PER_PATH];
    endfunction : all_in_path

    function automatic logic [7:0] flag_offset(int b);
        case (b)
            `PDSM_IDX_EVENT: flag_offset = `PDSM_OFS_EVENT;
            `PDSM_IDX_TEMP: flag_offset = `PDSM_OFS_TEMP;
            `PDSM_IDX_AUX: flag_offset = `PDSM_OFS_AUX;
            default: flag_offset = `PDSM_OFS_CUSTOM;
        endcase
    endfunction : flag_offset

    pdsm_path_state_type path_state [PATHS];
    pdsm_path_state_type path_state_next [PATHS];
    logic [PATHS-1:0] deactivate_transition;
    logic [PATHS-1:0] redeinit_transition;
    logic [PATHS-1:0] tx_on_done;
    logic [PATHS-1:0] tx_off_done;
    logic [PATHS-1:0] pending_reg;
    logic [PATHS-1:0] pending_next;
    logic [LANES-1:0] lane_off_req;

    assign lane_off_req = TX_LANE_DISABLE | TX_LANE_FORCED_SQUELCH;

    // ============================================================
    // Path state machines
    genvar gp;
    generate
        for (gp = 0; gp < PATHS; gp++) begin : g_path
            // Reinit keeps deactivate high until the path re-enters init
            assign deactivate_transition[gp] = DEACTIVATE_REQ[gp] |
                pending_reg[gp] | // [RULE11]
                any_in_path(lane_off_req, gp); // [RULE16]
            assign redeinit_transition[gp] = REDEINIT_REQ[gp] |
                pending_reg[gp]; // [RULE11]
            assign tx_on_done[gp] = all_in_path(TX_LANE_READY, gp); // [RULE8]
            // Lanes not asked to go off need not be quiet
            assign tx_off_done[gp] = all_in_path(
                TX_LANE_QUIET | ~lane_off_req, gp); // [RULE18]

            pdsm_path_fsm u_fsm ( // [RULE24]
                .clk(CLK),
                .ce(CE),
                .rst(RST),
                .deactivate_transition(deactivate_transition[gp]),
                .redeinit_transition(redeinit_transition[gp]),
                .deinit_transition(DEINIT_REQ[gp]),
                .init_done(INIT_DONE[gp]),
                .deinit_done(DEINIT_DONE[gp]),
                .tx_on_done(tx_on_done[gp]),
                .tx_off_done(tx_off_done[gp]),
                .path_state(path_state[gp]),
                .path_state_next(path_state_next[gp])
            );
        end
    endgenerate

    // ============================================================
    // Reinit pending per path
    always_comb begin
        pending_next = pending_reg;
        if (CE) begin
            for (int p = 0; p < PATHS; p++) begin
                // Staged setup is taken on entry to initializing
                if (path_state_next[p] == PS_INITIALIZING &&
                    path_state[p] != PS_INITIALIZING) begin
                    pending_next[p] = 1'b0;
                end
                // Set wins; a path with no selected lane is untouched;
                // a partly selected path still reinitialises whole
                if (REINIT_WR &&
                    any_in_path(REINIT_REQUEST_BITS, p)) begin
                    pending_next[p] = 1'b1; // [RULE11] [RULE12] [RULE14]
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // ============================================================
    // Lane outputs: quiesce, state and state changed
    logic [LANES-1:0] quiesce_reg;
    logic [LANES-1:0] quiesce_next;
    logic [LANES*3-1:0] lane_state_reg;
    logic [LANES*3-1:0] lane_state_next;
    logic [LANES-1:0] changed_reg;
    logic [LANES-1:0] changed_next;

    always_comb begin
        quiesce_next = quiesce_reg;
        lane_state_next = lane_state_reg;
        changed_next = changed_reg;
        if (CE) begin
            for (int l = 0; l < LANES; l++) begin
                case (path_state_next[l / LANES_PER_PATH])
                    PS_INITIALIZED, PS_TX_TURNING_OFF: begin
                        quiesce_next[l] = lane_off_req[l]; // [RULE17]
                    end
                    PS_TX_TURNING_ON: begin
                        // Unmuted; module auto-squelch sits downstream
                        quiesce_next[l] = 1'b0; // [RULE4] [RULE6]
                    end
                    PS_OPERATIONAL: begin
                        quiesce_next[l] = 1'b0; // [RULE9]
                    end
                    default: begin
                        // Controls are ignored here on purpose
                        quiesce_next[l] = 1'b1; // [RULE1] [RULE2]
                    end
                endcase
                lane_state_next[l*`PDSM_STATE_BITS +: `PDSM_STATE_BITS] =
                    path_state_next[l / LANES_PER_PATH]; // [RULE5]
                changed_next[l] =
                    path_state_next[l / LANES_PER_PATH] == PS_OPERATIONAL &&
                    path_state[l / LANES_PER_PATH] != PS_OPERATIONAL; // [RULE5]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            quiesce_reg <= '1;
            lane_state_reg <= '0;
            changed_reg <= '0;
        end else begin
            quiesce_reg <= quiesce_next;
            lane_state_reg <= lane_state_next;
            changed_reg <= changed_next;
        end
    end

    assign TX_QUIESCE = quiesce_reg;
    assign LANE_STATE = lane_state_reg;
    assign STATE_CHANGED = changed_reg;

    // ============================================================
    // Module flag bytes, clear on read, set wins over the clear
    logic [31:0] allow;
    logic [`PDSM_BYTE_BITS-1:0] flag_reg [`PDSM_FLAG_BYTES];
    logic [`PDSM_BYTE_BITS-1:0] flag_next [`PDSM_FLAG_BYTES];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    pdsm_flag_gate #(
        .LP_CUSTOM_MASK(LP_CUSTOM_MASK)
    ) u_gate (
        .mod_state(MOD_STATE),
        .allow(allow)
    );

    always_comb begin
        rdata_next = rdata_reg;
        for (int b = 0; b < `PDSM_FLAG_BYTES; b++) begin
            flag_next[b] = flag_reg[b];
        end
        if (CE) begin
            if (REG_RD) begin
                rdata_next = `PDSM_RDATA_UNMAPPED;
            end
            for (int b = 0; b < `PDSM_FLAG_BYTES; b++) begin
                if (REG_RD && REG_ADDR == flag_offset(b)) begin
                    rdata_next = flag_reg[b];
                    flag_next[b] = `PDSM_FLAG_RESET;
                end
                flag_next[b] = flag_next[b] |
                    (FLAG_EVENTS[b*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS] &
                    allow[b*`PDSM_BYTE_BITS +: `PDSM_BYTE_BITS]); // [RULE19]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg <= `PDSM_RDATA_UNMAPPED;
            for (int b = 0; b < `PDSM_FLAG_BYTES; b++) begin
                flag_reg[b] <= `PDSM_FLAG_RESET;
            end
        end else begin
            rdata_reg <= rdata_next;
            for (int b = 0; b < `PDSM_FLAG_BYTES; b++) begin
                flag_reg[b] <= flag_next[b];
            end
        end
    end

    assign REG_RDATA = rdata_reg;

    // ============================================================
    // Checks on path 0, lane 0, and on the module flag bytes
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_deinit_quiet_lane: assert property ( // [RULE1] [RULE2]
        (CE && path_state_next[0] == PS_DEINITIALIZING) |=> TX_QUIESCE[0])
        else $error("lane not quiet while path deinitializing");
    a_deinit_exit_wait: assert property ( // [RULE3]
        (CE && path_state[0] == PS_DEINITIALIZING && !DEINIT_DONE[0]) |=>
        path_state[0] == PS_DEINITIALIZING)
        else $error("deinitializing left before done");
    a_turnon_unmute: assert property ( // [RULE4]
        (CE && path_state_next[0] == PS_TX_TURNING_ON) |=> !TX_QUIESCE[0])
        else $error("lane muted while turning on");
    a_oper_changed_flag: assert property ( // [RULE5]
        (path_state[0] == PS_OPERATIONAL &&
        $past(path_state[0]) != PS_OPERATIONAL) |->
        STATE_CHANGED[0] && LANE_STATE[2:0] == PS_OPERATIONAL)
        else $error("operational entry not reported");
    a_turnon_deact: assert property ( // [RULE7]
        (CE && path_state[0] == PS_TX_TURNING_ON &&
        deactivate_transition[0]) |=> path_state[0] == PS_TX_TURNING_OFF)
        else $error("deactivate ignored while turning on");
    a_turnon_wait: assert property ( // [RULE8]
        (CE && path_state[0] == PS_TX_TURNING_ON &&
        !deactivate_transition[0] && !tx_on_done[0]) |=>
        path_state[0] == PS_TX_TURNING_ON)
        else $error("operational before lanes ready");
    a_oper_unmute: assert property ( // [RULE9]
        (CE && path_state[0] == PS_OPERATIONAL &&
        !deactivate_transition[0]) |=> !TX_QUIESCE[0] [*1] ##0
        path_state[0] == PS_OPERATIONAL)
        else $error("lane muted while operational");
    a_disable_turnoff: assert property ( // [RULE10] [RULE16]
        (CE && path_state[0] == PS_OPERATIONAL && TX_LANE_DISABLE[0]) |=>
        path_state[0] == PS_TX_TURNING_OFF ##1 !CE || TX_QUIESCE[0])
        else $error("disable did not start turning off");
    a_reinit_loop: assert property ( // [RULE11]
        (CE && REINIT_WR && REINIT_REQUEST_BITS[0] &&
        path_state[0] == PS_OPERATIONAL) |=>
        pending_reg[0] ##1 (!CE || path_state[0] == PS_TX_TURNING_OFF))
        else $error("reinit request did not deactivate path");
    a_reinit_other_path: assert property ( // [RULE14]
        (CE && REINIT_WR && !pending_reg[0] &&
        !any_in_path(REINIT_REQUEST_BITS, 0)) |=> !pending_reg[0])
        else $error("unselected path affected by reinit");
    a_turnoff_follow: assert property ( // [RULE17]
        (CE && path_state_next[0] == PS_TX_TURNING_OFF) |=>
        TX_QUIESCE[0] == $past(lane_off_req[0]))
        else $error("turning off ignores lane controls");
    a_turnoff_wait: assert property ( // [RULE18]
        (CE && path_state[0] == PS_TX_TURNING_OFF && !tx_off_done[0]) |=>
        path_state[0] == PS_TX_TURNING_OFF)
        else $error("initialized before lanes quiet");
    a_reset_group_flags: assert property ( // [RULE19] [RULE20]
        (CE && MOD_STATE inside {MS_RESETTING, MS_RESET, MS_MGMT_INIT} &&
        flag_reg[`PDSM_IDX_EVENT] == `PDSM_FLAG_RESET) |=>
        flag_reg[`PDSM_IDX_EVENT] == `PDSM_FLAG_RESET)
        else $error("module flag set in reset group");
    a_aux_low_power: assert property ( // [RULE21]
        (CE && MOD_STATE inside {MS_LOW_POWER, MS_FAULTED} &&
        flag_reg[`PDSM_IDX_AUX] == `PDSM_FLAG_RESET) |=>
        flag_reg[`PDSM_IDX_AUX] == `PDSM_FLAG_RESET)
        else $error("aux flag set in low power or fault");
    a_custom_low_power: assert property ( // [RULE22]
        (CE && MOD_STATE == MS_LOW_POWER) |=>
        (flag_reg[`PDSM_IDX_CUSTOM] & ~LP_CUSTOM_MASK &
        ~$past(flag_reg[`PDSM_IDX_CUSTOM])) == `PDSM_FLAG_RESET)
        else $error("custom flag set in low power");
    a_init_turnon: assert property ( // [RULE23]
        (CE && path_state[0] == PS_INITIALIZED && !redeinit_transition[0]
        && !deactivate_transition[0]) |=> path_state[0] == PS_TX_TURNING_ON)
        else $error("initialized did not turn on");

    c_reach_oper: cover property (
        path_state[0] == PS_TX_TURNING_ON ##1
        path_state[0] == PS_OPERATIONAL);
    c_reinit_entry: cover property (
        pending_reg[0] && path_state[0] == PS_DEINITIALIZING);
    c_flag_read: cover property (
        REG_RD && REG_ADDR == `PDSM_OFS_AUX && flag_reg[`PDSM_IDX_AUX] != 0);
endmodule : pdsm_top
